// *** hdl/spv_pkg.sv ***
// Overview of operation
// - stages run only in single-voltage modes
// - three overvoltage stages, own threshold, time
// - three undervoltage stages, own threshold, time
// - one fundamental magnitude, symmetric derived voltages
// - definite time delay, not depth dependent
// - overvoltage start while voltage above threshold
// - overvoltage trip after full operate time
// - fixed non-settable overvoltage start delay
// - operate time ranges per overvoltage stage
// - lowest overvoltage timer held by release delay
// - undervoltage start while voltage below threshold
// - undervoltage trip after full operate time
// - lowest undervoltage timer held by release delay
// - external input blocks undervoltage stages
// - internal block input suppresses undervoltage stages
// - voltage below floor blocks undervoltage stages
// - report maximum line voltage as measurement
// - start counter counts start assertions
// - trip counter counts trip assertions
// - record peak fault voltage in percent
package spv_pkg;

  localparam int SPV_NSTG = 6;
  localparam int SPV_NOV  = 3;

  // ********************
  // timing
  // ********************
  localparam int SPV_CLK_MHZ  = 100;
  localparam int SPV_TICK_MS  = 10;
  localparam int SPV_TICK_CYC = SPV_TICK_MS * SPV_CLK_MHZ * 1000;
  localparam logic [1:0]  SPV_OV_START_SMP = 2'h2;
  localparam logic [15:0] SPV_PCT_STEP     = 16'h0064;

  // ********************
  // register map
  // ********************
  localparam logic [7:0] SPV_CTRL_OFS = 8'h00;
  localparam logic [7:0] SPV_STAT_OFS = 8'h04;
  localparam logic [7:0] SPV_EVEN_OFS = 8'h08;
  localparam logic [3:0] SPV_STG_LO   = 4'h2;
  localparam logic [3:0] SPV_STG_HI   = 4'h7;
  localparam logic [2:0] SPV_CNT_HI3  = 3'h4;

  localparam int SPV_MODE_LSB  = 0;
  localparam int SPV_EXTEN_BIT = 2;
  localparam int SPV_INTEN_BIT = 3;
  localparam int SPV_FLOOR_LSB = 8;
  localparam int SPV_ST_LSB    = 0;
  localparam int SPV_TR_LSB    = 8;
  localparam int SPV_EN_BIT    = 16;
  localparam int SPV_BLK_BIT   = 17;
  localparam int SPV_MEAS_LSB  = 24;

  typedef enum logic [1:0] {
    SPV_MODE_OFF = 2'h0,
    SPV_MODE_LL  = 2'h1,
    SPV_MODE_LN  = 2'h2
  } spv_mode_t;

  // ********************
  // reset values and ranges
  // ********************
  localparam spv_mode_t   SPV_MODE_RST  = SPV_MODE_LL;
  localparam logic        SPV_EXTEN_RST = 1'b1;
  localparam logic        SPV_INTEN_RST = 1'b1;
  localparam logic [7:0]  SPV_FLOOR_RST = 8'h0a;
  localparam logic [7:0]  SPV_FLOOR_MAX = 8'h50;
  localparam logic [23:0] SPV_EVEN_RST  = 24'hffffff;
  localparam logic [7:0]  SPV_THR_RST [SPV_NSTG] = '{8'h78, 8'h82, 8'h82, 8'h50, 8'h46, 8'h46};
  localparam logic [7:0]  SPV_THR_MIN [SPV_NSTG] = '{8'h32, 8'h32, 8'h32, 8'h14, 8'h14, 8'h14};
  localparam logic [7:0]  SPV_THR_MAX [SPV_NSTG] = '{8'h96, 8'ha0, 8'ha0, 8'h78, 8'h78, 8'h78};
  localparam logic [15:0] SPV_OP_RST  [SPV_NSTG] = '{16'h0014, 16'h000a, 16'h000a,
                                                     16'h07d0, 16'h00c8, 16'h00c8};
  localparam logic [15:0] SPV_OP_MIN  [SPV_NSTG] = '{16'h0008, 16'h0008, 16'h0006,
                                                     16'h0008, 16'h0006, 16'h0006};
  localparam logic [15:0] SPV_TIME_MAX = 16'h7530;
  localparam logic [15:0] SPV_HOLD_MIN = 16'h0006;
  localparam logic [15:0] SPV_HOLD_RST = 16'h0006;

endpackage

// *** hdl/spv_stages.sv ***
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
module spv_stages
  import spv_pkg::*;
#(
  parameter int TICK_CYCLES = SPV_TICK_CYC
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SAMPLE_VALID,
  input  wire logic [7:0]  VOLT_PCT,
  input  wire logic        BLOCK_IN,
  input  wire logic        INT_BLOCK,
  output logic      [5:0]  START,
  output logic      [5:0]  TRIP,
  output logic      [23:0] EVENT
);

  // ********************
  // settings
  // ********************
  spv_mode_t   mode_q;
  logic        ext_en_q;
  logic        int_en_q;
  logic [7:0]  floor_q;
  logic [23:0] evt_en_q;
  logic [7:0]  thr_q  [SPV_NSTG];
  logic [15:0] op_q   [SPV_NSTG];
  logic [15:0] hold_q [SPV_NSTG];
  logic [5:0]  cnt_clr_q;

  logic [7:0]  pk_w   [SPV_NSTG];
  logic [7:0]  pct_w  [SPV_NSTG];
  logic [15:0] sc_w   [SPV_NSTG];
  logic [15:0] tc_w   [SPV_NSTG];

  logic [19:0] div_q;
  logic        tick;
  logic [7:0]  vin_q;
  logic        smp_q;
  logic        sync1_q;
  logic        sync2_q;
  logic        sync3_q;
  logic        blk_q;
  logic        stg_en;
  logic        uv_block;

  function automatic logic [15:0] clamp16(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // ********************
  // time base
  // ********************
  assign tick = (div_q == 20'(TICK_CYCLES - 1));

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_q <= 20'h0;
    end else if (tick) begin
      div_q <= 20'h0;
    end else begin
      div_q <= div_q + 20'h1;
    end
  end

  // ********************
  // measurement
  // ********************
  // single magnitude sample
  // symmetric system: every derived line voltage equals this per-unit value
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      vin_q <= 8'h0;
      smp_q <= 1'b0;
    end else begin
      smp_q <= SAMPLE_VALID;
      if (SAMPLE_VALID) begin
        vin_q <= VOLT_PCT;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      blk_q   <= 1'b0;
    end else begin
      sync1_q <= BLOCK_IN;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        blk_q <= sync3_q;
      end
    end
  end

  assign stg_en = (mode_q == SPV_MODE_LL) || (mode_q == SPV_MODE_LN);

  assign uv_block = (ext_en_q && blk_q) || (int_en_q && INT_BLOCK) || (vin_q < floor_q);

  // ********************
  // stages
  // ********************
  // six independent stages
  for (genvar s = 0; s < SPV_NSTG; s++) begin : g_stg
    localparam bit IS_OV = (s < SPV_NOV);
    localparam bit HOLD  = (s == 0) || (s == SPV_NOV);

    logic        raw;
    logic        fault;
    logic        trip_c;
    logic        inc;
    logic        hold_done;
    logic        clr;
    logic [1:0]  flt_q;
    logic [15:0] tmr_q;
    logic [15:0] hcnt_q;
    logic [15:0] acc_q;
    logic [16:0] acc_sum;
    logic [7:0]  pct_q;
    logic [7:0]  pk_q;
    logic        st_q;
    logic        tr_q;
    logic [3:0]  ev_q;
    logic [15:0] sc_q;
    logic [15:0] tc_q;

    assign raw = IS_OV ? (vin_q > thr_q[s]) : ((vin_q < thr_q[s]) && !uv_block);

    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        flt_q <= 2'h0;
      end else if (!raw) begin
        flt_q <= 2'h0;
      end else if (smp_q && (flt_q < SPV_OV_START_SMP)) begin
        flt_q <= flt_q + 2'h1;
      end
    end

    // filter only on the over side; under side starts at once
    assign fault = stg_en && raw && (!IS_OV || (flt_q == SPV_OV_START_SMP));

    assign trip_c = fault && (tmr_q >= op_q[s]);
    assign inc = fault && tick && (tmr_q < op_q[s]);
    assign hold_done = hcnt_q >= hold_q[s];
    assign clr = !fault && (!HOLD || hold_done);

    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        tmr_q  <= 16'h0;
        hcnt_q <= 16'h0;
      end else if (fault) begin
        hcnt_q <= 16'h0;
        if (inc) begin
          tmr_q <= tmr_q + 16'h1;
        end
      end else if (clr) begin
        tmr_q  <= 16'h0;
        hcnt_q <= 16'h0;
      end else if (tick && (tmr_q != 16'h0)) begin
        hcnt_q <= hcnt_q + 16'h1;
      end
    end

    // elapsed percent by repeated subtraction, catches up between ticks
    always_comb begin
      acc_sum = {1'b0, acc_q};
      if (inc) begin
        acc_sum = acc_sum + {1'b0, SPV_PCT_STEP};
      end
      if (acc_q >= op_q[s]) begin
        acc_sum = acc_sum - {1'b0, op_q[s]};
      end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        acc_q <= 16'h0;
        pct_q <= 8'h0;
      end else if (clr) begin
        acc_q <= 16'h0;
        pct_q <= 8'h0;
      end else begin
        acc_q <= acc_sum[15:0];
        if ((acc_q >= op_q[s]) && (pct_q != 8'hff)) begin
          pct_q <= pct_q + 8'h1;
        end
      end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        pk_q <= 8'h0;
      end else if (fault && !st_q) begin
        pk_q <= vin_q;
      end else if (fault && (IS_OV ? (vin_q > pk_q) : (vin_q < pk_q))) begin
        pk_q <= vin_q;
      end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        st_q <= 1'b0;
        tr_q <= 1'b0;
        ev_q <= 4'h0;
      end else begin
        st_q    <= fault;
        tr_q    <= trip_c;
        ev_q[0] <= evt_en_q[4*s]     && fault && !st_q;
        ev_q[1] <= evt_en_q[4*s + 1] && !fault && st_q;
        ev_q[2] <= evt_en_q[4*s + 2] && trip_c && !tr_q;
        ev_q[3] <= evt_en_q[4*s + 3] && !trip_c && tr_q;
      end
    end

    // edge counters
    // a count edge in the same cycle as a software clear restarts the count at one
    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        sc_q <= 16'h0;
        tc_q <= 16'h0;
      end else begin
        if (fault && !st_q) begin
          sc_q <= cnt_clr_q[s] ? 16'h1 : sc_q + 16'h1;
        end else if (cnt_clr_q[s]) begin
          sc_q <= 16'h0;
        end
        if (trip_c && !tr_q) begin
          tc_q <= cnt_clr_q[s] ? 16'h1 : tc_q + 16'h1;
        end else if (cnt_clr_q[s]) begin
          tc_q <= 16'h0;
        end
      end
    end

    assign START[s]        = st_q;
    assign TRIP[s]         = tr_q;
    assign EVENT[4*s +: 4] = ev_q;
    assign pk_w[s]         = pk_q;
    assign pct_w[s]        = pct_q;
    assign sc_w[s]         = sc_q;
    assign tc_w[s]         = tc_q;
  end

  // ********************
  // apb slave
  // ********************
  logic [2:0]  si;
  logic [2:0]  ci;
  logic        in_stg;
  logic        in_cnt;
  logic        setup;
  logic        wr_en;
  logic [31:0] rd_d;
  logic        err_d;

  assign si     = 3'(PADDR[6:4] - 3'h2);
  assign ci     = PADDR[4:2];
  assign in_stg = (PADDR[7:4] >= SPV_STG_LO) && (PADDR[7:4] <= SPV_STG_HI);
  assign in_cnt = (PADDR[7:5] == SPV_CNT_HI3) && (ci < 3'(SPV_NSTG));
  assign setup  = PSEL && !PENABLE;
  assign wr_en  = PSEL && PENABLE && PWRITE && !PSLVERR;
  // no wait state: read data is captured in the setup cycle
  assign PREADY = PSEL && PENABLE;

  always_comb begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    if (PADDR[1:0] != 2'h0) begin
      err_d = 1'b1;
    end else if (PADDR == SPV_CTRL_OFS) begin
      rd_d[SPV_MODE_LSB +: 2]  = mode_q;
      rd_d[SPV_EXTEN_BIT]      = ext_en_q;
      rd_d[SPV_INTEN_BIT]      = int_en_q;
      rd_d[SPV_FLOOR_LSB +: 8] = floor_q;
    end else if (PADDR == SPV_STAT_OFS) begin
      err_d                   = PWRITE;
      rd_d[SPV_ST_LSB +: 6]   = START;
      rd_d[SPV_TR_LSB +: 6]   = TRIP;
      rd_d[SPV_EN_BIT]        = stg_en;
      rd_d[SPV_BLK_BIT]       = uv_block;
      rd_d[SPV_MEAS_LSB +: 8] = vin_q;
    end else if (PADDR == SPV_EVEN_OFS) begin
      rd_d[23:0] = evt_en_q;
    end else if (in_stg) begin
      unique case (PADDR[3:2])
        2'h0: rd_d[7:0] = thr_q[si];
        2'h1: rd_d[15:0] = op_q[si];
        2'h2: rd_d[15:0] = hold_q[si];
        2'h3: begin
          err_d      = PWRITE;
          rd_d[7:0]  = pk_w[si];
          rd_d[15:8] = pct_w[si];
        end
      endcase
    end else if (in_cnt) begin
      rd_d = {tc_w[ci], sc_w[ci]};
    end else begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= PWRITE ? 32'h0 : rd_d;
      PSLVERR <= err_d;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_q    <= SPV_MODE_RST;
      ext_en_q  <= SPV_EXTEN_RST;
      int_en_q  <= SPV_INTEN_RST;
      floor_q   <= SPV_FLOOR_RST;
      evt_en_q  <= SPV_EVEN_RST;
      cnt_clr_q <= 6'h0;
      for (int i = 0; i < SPV_NSTG; i++) begin
        thr_q[i]  <= SPV_THR_RST[i];
        op_q[i]   <= SPV_OP_RST[i];
        hold_q[i] <= SPV_HOLD_RST;
      end
    end else begin
      cnt_clr_q <= 6'h0;
      if (wr_en) begin
        if (PADDR == SPV_CTRL_OFS) begin
          mode_q   <= spv_mode_t'(PWDATA[SPV_MODE_LSB +: 2]);
          ext_en_q <= PWDATA[SPV_EXTEN_BIT];
          int_en_q <= PWDATA[SPV_INTEN_BIT];
          floor_q  <= (PWDATA[SPV_FLOOR_LSB +: 8] > SPV_FLOOR_MAX) ?
                      SPV_FLOOR_MAX : PWDATA[SPV_FLOOR_LSB +: 8];
        end else if (PADDR == SPV_EVEN_OFS) begin
          evt_en_q <= PWDATA[23:0];
        end else if (in_stg) begin
          unique case (PADDR[3:2])
            2'h0: thr_q[si] <= 8'(clamp16({8'h0, PWDATA[7:0]},
                                          {8'h0, SPV_THR_MIN[si]},
                                          {8'h0, SPV_THR_MAX[si]}));
            2'h1: op_q[si] <= clamp16(PWDATA[15:0], SPV_OP_MIN[si], SPV_TIME_MAX);
            2'h2: hold_q[si] <= clamp16(PWDATA[15:0], SPV_HOLD_MIN, SPV_TIME_MAX);
            2'h3: begin
            end
          endcase
        end else if (in_cnt) begin
          cnt_clr_q[ci] <= 1'b1;
        end
      end
    end
  end

endmodule // spv_stages

// *** verification/spv_stages_checker.sv ***
`timescale 1ns/100ps
module spv_stages_checker #(
  parameter int TICK_CYCLES = 40
) (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        SAMPLE_VALID,
  input wire logic [7:0]  VOLT_PCT,
  input wire logic        BLOCK_IN,
  input wire logic        INT_BLOCK,
  input wire logic [5:0]  START,
  input wire logic [5:0]  TRIP,
  input wire logic [23:0] EVENT
);
  logic [2:0]  sv_age_q;
  logic [15:0] run_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // saturating ages: a start may only follow a fresh sample
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sv_age_q <= 3'h7;
    end else if (SAMPLE_VALID) begin
      sv_age_q <= 3'h0;
    end else if (sv_age_q != 3'h7) begin
      sv_age_q <= sv_age_q + 3'h1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      run_q <= 16'h0;
    end else if (!START[2]) begin
      run_q <= 16'h0;
    end else if (run_q != 16'hffff) begin
      run_q <= run_q + 16'h1;
    end
  end

  a_ready_phase: assert property (PREADY == (PSEL && PENABLE))
    else $error("ready not equal to access phase");
  a_misalign_err: assert property ((PSEL && !PENABLE && PADDR[1:0] != 2'h0) |=> PSLVERR)
    else $error("misaligned access not refused");
  a_status_ro: assert property ((PSEL && !PENABLE && PWRITE && PADDR == 8'h04) |=> PSLVERR)
    else $error("status write not refused");
  a_write_rdata: assert property ((PSEL && !PENABLE && PWRITE) |=> PRDATA == 32'h0)
    else $error("read data not zero on write");
  a_over_start_smp: assert property ($rose(START[1]) |-> sv_age_q <= 3'h4)
    else $error("over start without recent sample");
  a_trip_has_start: assert property ((TRIP & ~START) == 6'h0)
    else $error("trip without start");
  a_trip_after_time: assert property ($rose(TRIP[2]) |-> int'(run_q) >= 5 * TICK_CYCLES)
    else $error("trip before operate time");
  a_start_event: assert property ($rose(START[0]) |-> EVENT[0])
    else $error("start-on event missing");
  a_trip_off_event: assert property ($fell(TRIP[3]) |-> EVENT[15])
    else $error("trip-off event missing");
  a_event_single: assert property (EVENT[2] |=> !EVENT[2])
    else $error("event longer than one cycle");

  c_over_trip: cover property ($rose(TRIP[0]));
  c_under_trip: cover property ($rose(TRIP[3]));
  c_start_drop: cover property ($fell(START[2]));
endmodule // spv_stages_checker

bind spv_stages spv_stages_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// *** verification/spv_stages_test.sv ***
`timescale 1ns/100ps
module spv_stages_test;
  import spv_pkg::*;
  logic        clk, sys_rst, psel, penable, pwrite, sv, blk, iblk;
  logic        pready, pslverr, er;
  logic [7:0]  paddr, volt, v;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [5:0]  start, trip;
  logic [23:0] evt;
  int          n_errors, cmp_count, cyc;
  // alarm stage set below trip stage
  logic [7:0]  thr [6] = '{8'h6e, 8'h78, 8'h82, 8'h50, 8'h46, 8'h3c};
  logic [7:0]  corner [4] = '{8'h6e, 8'h6f, 8'h09, 8'h0a};

  spv_stages #(.TICK_CYCLES(40)) dut (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SAMPLE_VALID(sv), .VOLT_PCT(volt), .BLOCK_IN(blk),
    .INT_BLOCK(iblk), .START(start), .TRIP(trip), .EVENT(evt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only pready or the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  task automatic smp(input logic [7:0] val, input int k);
    repeat (k) begin
      @(posedge clk);
      volt <= val;
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // floor is at its default of 10 percent whenever this is used
  function automatic logic [5:0] exp_st(input logic [7:0] x);
    logic [5:0] e;
    for (int i = 0; i < 3; i++) begin
      e[i] = x > thr[i];
      e[i+3] = x < thr[i+3] && x >= 8'h0a;
    end
    return e;
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    {psel, penable, pwrite, sv, blk, iblk} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    volt = 8'h64;
    sys_rst = 1'b1;
    {n_errors, cmp_count, cyc} = '0;
    seed = 32'hf794;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(8'h00, 32'h0a0d);
    rdc(8'h08, 32'hffffff);
    for (int s = 0; s < 6; s++) begin
      rdc(8'h20 + 8'(16 * s), {24'h0, SPV_THR_RST[s]});
      rdc(8'h24 + 8'(16 * s), {16'h0, SPV_OP_RST[s]});
      bus(1'b1, 8'h20 + 8'(16 * s), {24'h0, thr[s]});
      bus(1'b1, 8'h24 + 8'(16 * s), 32'h1);
      rdc(8'h24 + 8'(16 * s), {16'h0, SPV_OP_MIN[s]});
    end
    bus(1'b1, 8'h00, 32'hff0d);
    rdc(8'h00, 32'h500d);
    bus(1'b1, 8'h00, 32'h0a0d);
    bus(1'b1, 8'h04, 32'h0);
    chk(er, 32'h1);
    bus(1'b0, 8'h14, 32'h0);
    chk(er, 32'h1);
    // misaligned read must be refused
    bus(1'b0, 8'h22, 32'h0);
    chk(er, 32'h1);
    $display("registers done");
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      v = (i < 4) ? corner[i] : 8'(seed % 200);
      smp(v, 2);
      chk(start, exp_st(v));
      bus(1'b0, 8'h04, 32'h0);
      chk(rd[31:24], v);
    end
    $display("random levels done");
    smp(8'h64, 2);
    for (int s = 0; s < 6; s++) bus(1'b1, 8'h80 + 8'(4 * s), 32'h0);
    smp(8'hc8, 1);
    chk(start, 6'h0);
    smp(8'hc8, 1);
    chk(start, 6'h07);
    smp(8'hc8, 70);
    chk(trip, 6'h07);
    rdc(8'h80, 32'h00010001);
    rdc(8'h88, 32'h00010001);
    rdc(8'h2c, 32'h000064c8);
    $display("over trip done");
    smp(8'h64, 2);
    bus(1'b1, 8'h00, 32'h0a0c);
    smp(8'hc8, 2);
    chk(start, 6'h0);
    // code 3 is off as well
    bus(1'b1, 8'h00, 32'h0a0f);
    smp(8'hc8, 2);
    chk(start, 6'h0);
    smp(8'h64, 2);
    bus(1'b1, 8'h00, 32'h0a0e);
    smp(8'hc8, 2);
    chk(start, 6'h07);
    $display("mode done");
    smp(8'h32, 70);
    chk(trip, 6'h38);
    blk <= 1'b1;
    repeat (8) @(posedge clk);
    chk(start, 6'h0);
    blk <= 1'b0;
    repeat (8) @(posedge clk);
    chk(start, 6'h38);
    iblk <= 1'b1;
    repeat (3) @(posedge clk);
    chk(start, 6'h0);
    iblk <= 1'b0;
    $display("under blocks done");
    // held timer must finish before the fresh operate time ends
    bus(1'b1, 8'h24, 32'h14);
    smp(8'h64, 50);
    bus(1'b1, 8'h28, 32'h64);
    smp(8'h73, 67);
    smp(8'h64, 13);
    smp(8'h73, 85);
    chk(trip[0], 32'h1);
    chk(trip[1], 32'h0);
    $display("hold done");
    report_and_stop();
  end
endmodule // spv_stages_test
